// File: sff_forward_filter.sv
// forwarding decision: trapping, mirroring, vlan and mac lookup, learning
//
// The APB register port and the placing of the registers were decided locally.
`default_nettype none
module sff_forward_filter #(
    parameter int STATIC_ENTRIES = 8,
    parameter int DYN_ENTRIES    = 16
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        inValid,
    input  wire logic [2:0]  inPort,
    input  wire logic [47:0] inDa,
    input  wire logic [47:0] inSa,
    input  wire logic        inTagged,
    input  wire logic [11:0] inVid,
    input  wire logic        inBad,
    input  wire logic        inIsIp,
    input  wire logic [3:0]  inIpVersion,
    input  wire logic [7:0]  inIpProto,
    input  wire logic        inIpv6Mcast,
    input  wire logic [7:0]  inHopLimit,
    input  wire logic [7:0]  inNextHdr,
    input  wire logic [7:0]  inHbhNextHdr,
    input  wire logic [7:0]  inTailTag,
    output logic             outValid,
    output logic [4:0]       outDest,
    output logic             outDrop,
    output logic             outTrap,
    output logic             outMirror,
    output logic [1:0]       outSrcTag,
    output logic [6:0]       outFid
);
    localparam int SW = $clog2(STATIC_ENTRIES);
    localparam int DW = $clog2(DYN_ENTRIES);

    // ==========================================================
    // apb slave, one wait cycle then answer
    logic [7:0]  gctrl5;
    logic [7:0]  gctrl12;
    logic [7:0]  gctrl164;
    logic [7:0]  pctrl1 [sff_pkg::NPORTS];
    logic [7:0]  pctrl2 [sff_pkg::NPORTS];
    logic [11:0] portDefaultVlan [sff_pkg::NPORTS];
    logic [31:0] staLo;
    logic [SW-1:0] staIdx;
    logic [15:0] learnedCount;
    logic [15:0] droppedCount;
    logic [sff_pkg::IDX_W-1:0] idx;
    logic        wrEn;
    logic [31:0] rdMux;
    logic        rdOk;

    assign idx  = paddr[11:2];
    assign wrEn = psel && penable && pready && pwrite && !pslverr;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        rdOk  = 1'b1;
        if (idx == sff_pkg::IDX_GCTRL5)
            rdMux = {24'h00_0000, gctrl5};
        else if (idx == sff_pkg::IDX_GCTRL12)
            rdMux = {24'h00_0000, gctrl12};
        else if (idx == sff_pkg::IDX_GCTRL164)
            rdMux = {24'h00_0000, gctrl164};
        else if (idx >= sff_pkg::IDX_PCTRL1 && idx < sff_pkg::IDX_PCTRL1 + 10'h005)
            rdMux = {24'h00_0000, pctrl1[3'(idx - sff_pkg::IDX_PCTRL1)]};
        else if (idx >= sff_pkg::IDX_PCTRL2 && idx < sff_pkg::IDX_PCTRL2 + 10'h005)
            rdMux = {24'h00_0000, pctrl2[3'(idx - sff_pkg::IDX_PCTRL2)]};
        else if (idx >= sff_pkg::IDX_PORT_DEFAULT_VLAN && idx < sff_pkg::IDX_PORT_DEFAULT_VLAN + 10'h005)
            rdMux = {20'h0_0000, portDefaultVlan[3'(idx - sff_pkg::IDX_PORT_DEFAULT_VLAN)]};
        else if (idx == sff_pkg::IDX_STA_LO)
            rdMux = staLo;
        else if (idx == sff_pkg::IDX_STA_IDX)
            rdMux = 32'(staIdx);
        else if (idx == sff_pkg::IDX_LEARNED)
            rdMux = {16'h0000, learnedCount};
        else if (idx == sff_pkg::IDX_DROPPED)
            rdMux = {16'h0000, droppedCount};
        else if (idx == sff_pkg::IDX_VLAN || idx == sff_pkg::IDX_STA_HI)
            rdMux = 32'h0000_0000;
        else
            rdOk = 1'b0;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !rdOk;
            prdata  <= (psel && penable && !pready && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gctrl5   <= sff_pkg::GCTRL_RST;
            gctrl12  <= sff_pkg::GCTRL_RST;
            gctrl164 <= sff_pkg::GCTRL_RST;
            staLo    <= 32'h0000_0000;
            staIdx   <= '0;
        end
        else if (wrEn)
        begin
            if (idx == sff_pkg::IDX_GCTRL5)
                gctrl5 <= pwdata[7:0];
            if (idx == sff_pkg::IDX_GCTRL12)
                gctrl12 <= pwdata[7:0];
            if (idx == sff_pkg::IDX_GCTRL164)
                gctrl164 <= pwdata[7:0];
            if (idx == sff_pkg::IDX_STA_LO)
                staLo <= pwdata;
            if (idx == sff_pkg::IDX_STA_IDX)
                staIdx <= pwdata[SW-1:0];
        end
    end

    // per-port mirror, filter and default vlan settings
    genvar gp;
    generate
        for (gp = 0; gp < sff_pkg::NPORTS; gp++)
        begin : g_port
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    pctrl1[gp]          <= sff_pkg::PCTRL_RST;
                    pctrl2[gp]          <= sff_pkg::PCTRL_RST;
                    portDefaultVlan[gp] <= sff_pkg::PORT_DEFAULT_VLAN_RST;
                end
                else if (wrEn)
                begin
                    if (idx == sff_pkg::IDX_PCTRL1 + 10'(gp))
                        pctrl1[gp] <= pwdata[7:0];
                    if (idx == sff_pkg::IDX_PCTRL2 + 10'(gp))
                        pctrl2[gp] <= pwdata[7:0];
                    if (idx == sff_pkg::IDX_PORT_DEFAULT_VLAN + 10'(gp))
                        portDefaultVlan[gp] <= pwdata[11:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // vlan table, slot chosen by low vid bits, full vid kept
    logic [24:0] vlanTab [sff_pkg::VLAN_ENTRIES];
    logic [sff_pkg::VLAN_ENTRIES-1:0] vlanValid;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            vlanValid <= '0;
        else if (wrEn && idx == sff_pkg::IDX_VLAN)
            vlanValid[pwdata[6:0]] <= pwdata[sff_pkg::VT_VALID];
    end

    always_ff @(posedge clk)
    begin
        if (wrEn && idx == sff_pkg::IDX_VLAN)
            vlanTab[pwdata[6:0]] <= pwdata[24:0];
    end

    // ==========================================================
    // stage 1: vlan resolution, done before any mac table access
    logic [11:0] effVid;
    logic [24:0] vEntry;
    logic        vHit;
    logic        vlanMode;
    logic        filterDrop;
    logic [4:0]  srcMask;
    logic        s1Valid;
    logic        s1VlanOk;
    logic [2:0]  s1Port;
    logic [47:0] s1Da;
    logic [47:0] s1Sa;
    logic [6:0]  s1Fid;
    logic [4:0]  s1Members;
    logic        s1Bad;
    logic        s1Igmp;
    logic        s1Mld;
    logic [7:0]  s1Tag;
    logic        mldBase;
    logic        mldExt;

    assign vlanMode = gctrl5[sff_pkg::G5_VLAN];
    assign effVid   = (vlanMode && (!inTagged || inVid == 12'h000)) ?
                      portDefaultVlan[inPort] : inVid;
    assign vEntry   = vlanTab[effVid[6:0]];
    assign vHit     = vlanValid[effVid[6:0]] && vEntry[11:0] == effVid;
    assign srcMask  = 5'h01 << inPort;
    // filtering needs membership; discard needs the port default
    assign filterDrop = (pctrl2[inPort][sff_pkg::P2_INFILT] &&
                         !(|(vEntry[16:12] & srcMask))) ||
                        (pctrl2[inPort][sff_pkg::P2_DISCARD] &&
                         effVid != portDefaultVlan[inPort]);

    function automatic logic nhMatch(input logic [7:0] nh, input logic ext);
        nhMatch = nh == sff_pkg::NH_ICMP || nh == sff_pkg::NH_ICMP6 ||
                  (ext && (nh == sff_pkg::NH_ROUTE || nh == sff_pkg::NH_FRAG ||
                           nh == sff_pkg::NH_ESP || nh == sff_pkg::NH_AUTH ||
                           nh == sff_pkg::NH_DEST));
    endfunction

    // extended header set only counts with the option bit
    assign mldBase = inIpv6Mcast && inHopLimit == sff_pkg::HOP_ONE;
    assign mldExt  = gctrl164[sff_pkg::G164_OPT];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s1Valid   <= 1'b0;
            s1VlanOk  <= 1'b0;
            s1Port    <= 3'h0;
            s1Da      <= 48'h0;
            s1Sa      <= 48'h0;
            s1Fid     <= 7'h00;
            s1Members <= 5'h00;
            s1Bad     <= 1'b0;
            s1Igmp    <= 1'b0;
            s1Mld     <= 1'b0;
            s1Tag     <= 8'h00;
        end
        else
        begin
            s1Valid  <= inValid;
            // unknown vid drops outright in vlan mode
            s1VlanOk <= !vlanMode || (vHit && !filterDrop);
            s1Port   <= inPort;
            s1Da     <= inDa;
            s1Sa     <= inSa;
            s1Fid    <= vlanMode ? vEntry[23:17] : 7'h00;
            s1Members <= vlanMode ? vEntry[16:12] : sff_pkg::ALL_MASK;
            s1Bad    <= inBad;
            s1Igmp   <= gctrl5[sff_pkg::G5_IGMP] && inIsIp &&
                        inIpVersion == sff_pkg::IPV4_VERSION &&
                        inIpProto == sff_pkg::PROTO_IGMP;
            s1Mld    <= gctrl164[sff_pkg::G164_MLD] && mldBase &&
                        (nhMatch(inNextHdr, mldExt) ||
                         (inNextHdr == sff_pkg::NH_HBH &&
                          nhMatch(inHbhNextHdr, mldExt)));
            s1Tag    <= inTailTag;
        end
    end

    // ==========================================================
    // static mac table
    logic [47:0] staMac   [STATIC_ENTRIES];
    logic [4:0]  staPorts [STATIC_ENTRIES];
    logic [6:0]  staFid   [STATIC_ENTRIES];
    logic [STATIC_ENTRIES-1:0] staUse;
    logic [STATIC_ENTRIES-1:0] staValid;
    logic [STATIC_ENTRIES-1:0] staHitVec;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            staValid <= '0;
            staUse   <= '0;
        end
        else if (wrEn && idx == sff_pkg::IDX_STA_HI)
        begin
            staValid[staIdx] <= pwdata[sff_pkg::SH_VALID];
            staUse[staIdx]   <= pwdata[sff_pkg::SH_USE];
        end
    end

    always_ff @(posedge clk)
    begin
        if (wrEn && idx == sff_pkg::IDX_STA_HI)
        begin
            staMac[staIdx]   <= {pwdata[15:0], staLo};
            staPorts[staIdx] <= pwdata[sff_pkg::SH_PORT_LSB +: 5];
            staFid[staIdx]   <= pwdata[sff_pkg::SH_FID_LSB +: 7];
        end
    end

    // ==========================================================
    // dynamic mac table
    logic [47:0] dynMac   [DYN_ENTRIES];
    logic [6:0]  dynFid   [DYN_ENTRIES];
    logic [2:0]  dynPort  [DYN_ENTRIES];
    logic [15:0] dynStamp [DYN_ENTRIES];
    logic [DYN_ENTRIES-1:0] dynValid;
    logic [DYN_ENTRIES-1:0] daHitVec;
    logic [DYN_ENTRIES-1:0] saHitVec;

    genvar ge;
    generate
        for (ge = 0; ge < STATIC_ENTRIES; ge++)
        begin : g_sta
            // id compared only when the entry asks for it
            assign staHitVec[ge] = staValid[ge] && staMac[ge] == s1Da &&
                                   (!staUse[ge] || staFid[ge] == s1Fid);
        end
        for (ge = 0; ge < DYN_ENTRIES; ge++)
        begin : g_dyn
            assign daHitVec[ge] = dynValid[ge] && dynMac[ge] == s1Da && dynFid[ge] == s1Fid;
            assign saHitVec[ge] = dynValid[ge] && dynMac[ge] == s1Sa && dynFid[ge] == s1Fid;
        end
    endgenerate

    logic [4:0]    staDest;
    logic [2:0]    dynDest;
    logic [DW-1:0] saIdx;
    logic [DW-1:0] freeIdx;
    logic          freeAny;

    always_comb
    begin
        staDest = 5'h00;
        dynDest = 3'h0;
        saIdx   = '0;
        freeIdx = '0;
        freeAny = 1'b0;
        for (int i = STATIC_ENTRIES - 1; i >= 0; i--)
            if (staHitVec[i])
                staDest = staPorts[i];
        for (int i = DYN_ENTRIES - 1; i >= 0; i--)
        begin
            if (daHitVec[i])
                dynDest = dynPort[i];
            if (saHitVec[i])
                saIdx = DW'(i);
            if (!dynValid[i])
            begin
                freeIdx = DW'(i);
                freeAny = 1'b1;
            end
        end
    end

    // ==========================================================
    // stage 2: destination and mirror decision
    logic       hostDirect;
    logic       trap;
    logic [4:0] baseDest;
    logic       mirror;
    logic       txHit;
    logic       rxSniff;
    logic [4:0] snifferMask;
    logic [4:0] txMask;
    logic       drop;

    always_comb
    begin
        for (int p = 0; p < sff_pkg::NPORTS; p++)
        begin
            snifferMask[p] = pctrl1[p][sff_pkg::P1_SNIFFER];
            txMask[p]      = pctrl1[p][sff_pkg::P1_TX];
        end
    end

    assign hostDirect = s1Port == sff_pkg::HOST_PORT && gctrl12[sff_pkg::G12_TAIL] &&
                        !s1Tag[sff_pkg::TAG_LOOKUP];
    assign trap       = (s1Igmp || s1Mld) && s1Port != sff_pkg::HOST_PORT;
    assign rxSniff    = pctrl1[s1Port][sff_pkg::P1_RX];

    always_comb
    begin
        drop     = 1'b0;
        baseDest = 5'h00;
        if (!s1VlanOk || s1Bad)
            drop = 1'b1;
        else if (trap)
            baseDest = sff_pkg::HOST_MASK;
        else if (hostDirect)
        begin
            // one-hot or all ones; anything else is reserved
            if (s1Tag[3:0] == sff_pkg::TAG_ALL || $onehot(s1Tag[3:0]))
                baseDest = {1'b0, s1Tag[3:0]};
            else
                drop = 1'b1;
        end
        else if (|staHitVec)
            baseDest = staDest;
        else if (|daHitVec)
            baseDest = 5'h01 << dynDest;
        else
            baseDest = s1Members;
        // the ingress port is removed from the base destination, not from the sniffer ports added for mirroring
        baseDest = baseDest & ~(5'h01 << s1Port);
        if (baseDest == 5'h00)
            drop = 1'b1;
    end

    assign txHit = |(baseDest & txMask);
    always_comb
    begin
        if (!s1VlanOk || snifferMask == 5'h00)
            mirror = 1'b0;
        else if (s1Bad)
            mirror = rxSniff && pctrl1[s1Port][sff_pkg::P1_BAD];
        else if (gctrl5[sff_pkg::G5_MIRROR_AND])
            mirror = rxSniff && txHit;
        else
            mirror = rxSniff || txHit;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            outValid  <= 1'b0;
            outDest   <= 5'h00;
            outDrop   <= 1'b0;
            outTrap   <= 1'b0;
            outMirror <= 1'b0;
            outSrcTag <= 2'h0;
            outFid    <= 7'h00;
        end
        else
        begin
            outValid  <= s1Valid;
            outDest   <= s1Valid ? (baseDest | (mirror ? snifferMask : 5'h00)) : 5'h00;
            outDrop   <= s1Valid && drop && !mirror;
            outTrap   <= s1Valid && trap && s1VlanOk && !s1Bad;
            outMirror <= s1Valid && mirror;
            // ingress port code for the processor side
            outSrcTag <= gctrl12[sff_pkg::G12_TAIL] ? s1Port[1:0] : 2'h0;
            outFid    <= s1Fid;
        end
    end

    // ==========================================================
    // learning; only frames that passed vlan checks reach here
    logic          learnOk;
    logic [DW-1:0] replPtr;
    logic [DW-1:0] wrSlot;
    logic [15:0]   stampClock;

    assign learnOk = s1Valid && s1VlanOk && !s1Bad;
    assign wrSlot  = freeAny ? freeIdx : replPtr;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dynValid     <= '0;
            replPtr      <= '0;
            stampClock   <= 16'h0000;
            learnedCount <= 16'h0000;
            droppedCount <= 16'h0000;
        end
        else
        begin
            stampClock <= stampClock + 16'h0001;
            if (s1Valid && drop && !mirror)
                droppedCount <= droppedCount + 16'h0001;
            if (learnOk && !(|saHitVec))
            begin
                dynValid[wrSlot] <= 1'b1;
                learnedCount     <= learnedCount + 16'h0001;
                // full table: overwrite in rotation, no aging here
                if (!freeAny)
                    replPtr <= replPtr + DW'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (learnOk && |saHitVec)
            dynStamp[saIdx] <= stampClock;
        else if (learnOk)
        begin
            dynMac[wrSlot]   <= s1Sa;
            dynFid[wrSlot]   <= s1Fid;
            dynPort[wrSlot]  <= s1Port;
            dynStamp[wrSlot] <= stampClock;
        end
    end
endmodule
`default_nettype wire

// File: sff_fwd_props.sv
// port assertions for the forwarding filter
`default_nettype none
module sff_fwd_props (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       inValid,
    input wire logic [2:0] inPort,
    input wire logic       outValid,
    input wire logic [4:0] outDest,
    input wire logic       outDrop,
    input wire logic       outTrap,
    input wire logic       outMirror,
    input wire logic [1:0] outSrcTag
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // =========================================================
    // frame path
    sequence taken_s;
        inValid;
    endsequence
    lat_frame_a: assert property (taken_s |-> ##2 outValid) else $error("late result");
    no_spur_a: assert property (outValid |-> $past(inValid, 2)) else $error("extra result");
    trap_host_a: assert property (outTrap && !outMirror |-> outDest == sff_pkg::HOST_MASK)
        else $error("trap dest");
    host_keep_a: assert property (taken_s ##0 inPort == sff_pkg::HOST_PORT |-> ##2 !outTrap)
        else $error("host trapped");
    drop_none_a: assert property (outDrop |-> outDest == 5'h00) else $error("drop dest");
    mirror_dest_a: assert property (outMirror |-> outDest != 5'h00) else $error("mirror");
    src_tag_a: assert property (outValid && outSrcTag != 2'h0 |-> {1'b0, outSrcTag} == $past(inPort, 2))
        else $error("source tag");
    // =========================================================
    // register bus, one wait state
    apb_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("no ready");
    err_pair_a: assert property (pslverr |-> pready) else $error("lone error");
endmodule
bind sff_forward_filter sff_fwd_props i_sff_fwd_props (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .inValid(inValid), .inPort(inPort),
    .outValid(outValid), .outDest(outDest), .outDrop(outDrop), .outTrap(outTrap),
    .outMirror(outMirror), .outSrcTag(outSrcTag));
`default_nettype wire

// File: sff_host_model.sv
// host processor model on the uplink port
`default_nettype none
module sff_host_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       trapped,
    input  wire logic [1:0] srcTag,
    output logic      [7:0] tailTag
);
    // =========================================================
    // reply tag: back to the port the trapped frame came from
    always_ff @(posedge clk or posedge reset)
        if (reset)
            tailTag <= 8'h80;
        else if (trapped)
            tailTag <= {4'h0, 4'h1 << srcTag};
endmodule
`default_nettype wire

// File: sff_pkg.sv
// constants shared by the switch forwarding filter
`default_nettype none
package sff_pkg;
    // ==========================================================
    // geometry
    localparam int NPORTS          = 5;
    localparam int VLAN_ENTRIES    = 128;
    localparam int FID_W           = 7;
    localparam int VID_W           = 12;
    localparam int IDX_W           = 10;
    localparam logic [2:0] HOST_PORT = 3'h4;
    localparam logic [4:0] HOST_MASK = 5'h10;
    localparam logic [4:0] ALL_MASK  = 5'h1F;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_GCTRL5   = 10'h005;
    localparam logic [IDX_W-1:0] IDX_GCTRL12  = 10'h00C;
    localparam logic [IDX_W-1:0] IDX_GCTRL164 = 10'h0A4;
    localparam logic [IDX_W-1:0] IDX_PCTRL1   = 10'h020;
    localparam logic [IDX_W-1:0] IDX_PCTRL2   = 10'h028;
    localparam logic [IDX_W-1:0] IDX_PORT_DEFAULT_VLAN     = 10'h030;
    localparam logic [IDX_W-1:0] IDX_VLAN     = 10'h040;
    localparam logic [IDX_W-1:0] IDX_STA_LO   = 10'h041;
    localparam logic [IDX_W-1:0] IDX_STA_HI   = 10'h042;
    localparam logic [IDX_W-1:0] IDX_STA_IDX  = 10'h043;
    localparam logic [IDX_W-1:0] IDX_LEARNED  = 10'h044;
    localparam logic [IDX_W-1:0] IDX_DROPPED  = 10'h045;
    // ==========================================================
    // field positions
    localparam int G5_MIRROR_AND = 0;
    localparam int G5_IGMP       = 6;
    localparam int G5_VLAN       = 7;
    localparam int G12_TAIL      = 1;
    localparam int G164_MLD      = 2;
    localparam int G164_OPT      = 3;
    localparam int P1_BAD        = 4;
    localparam int P1_TX         = 5;
    localparam int P1_RX         = 6;
    localparam int P1_SNIFFER    = 7;
    localparam int P2_DISCARD    = 5;
    localparam int P2_INFILT     = 6;
    localparam int VT_VALID      = 31;
    localparam int VT_FID_LSB    = 17;
    localparam int VT_MEM_LSB    = 12;
    localparam int SH_PORT_LSB   = 16;
    localparam int SH_FID_LSB    = 21;
    localparam int SH_USE        = 28;
    localparam int SH_VALID      = 29;
    localparam int TAG_LOOKUP    = 7;
    // ==========================================================
    // reset values
    localparam logic [7:0]  GCTRL_RST = 8'h00;
    localparam logic [7:0]  PCTRL_RST = 8'h00;
    localparam logic [11:0] PORT_DEFAULT_VLAN_RST  = 12'h001;
    // ==========================================================
    // protocol codes
    localparam logic [3:0] IPV4_VERSION = 4'h4;
    localparam logic [7:0] PROTO_IGMP   = 8'h02;
    localparam logic [7:0] HOP_ONE      = 8'h01;
    localparam logic [7:0] NH_HBH       = 8'h00;
    localparam logic [7:0] NH_ICMP      = 8'h01;
    localparam logic [7:0] NH_ICMP6     = 8'h3A;
    localparam logic [7:0] NH_ROUTE     = 8'h2B;
    localparam logic [7:0] NH_FRAG      = 8'h2C;
    localparam logic [7:0] NH_ESP       = 8'h32;
    localparam logic [7:0] NH_AUTH      = 8'h33;
    localparam logic [7:0] NH_DEST      = 8'h3C;
    localparam logic [3:0] TAG_ALL      = 4'hF;
endpackage
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the forwarding filter
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, inValid = 0, inTagged = 0;
    logic inBad = 0, inIsIp = 0, inIpv6Mcast = 0, pready, pslverr, perr;
    logic outValid, outDrop, outTrap, outMirror;
    logic [11:0] paddr = '0, inVid = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [47:0] inDa = '0, inSa = '0;
    logic [7:0] inIpProto = '0, inHopLimit = '0, inNextHdr = '0, inHbhNextHdr = '0, inTailTag;
    logic [3:0] inIpVersion = '0;
    logic [2:0] inPort = '0;
    logic [4:0] outDest;
    logic [1:0] outSrcTag;
    logic [6:0] outFid;
    logic [31:0] mldTab [0:12] = '{32'h0013A000, 32'h4013A001, 32'h4023A000, 32'h40100011,
        32'h40101001, 32'h401003A1, 32'h4012B000, 32'hC012B001, 32'hC012C001, 32'hC0132001,
        32'hC0133001, 32'hC013C001, 32'hC01002B1};
    int err_total = 0, n_tests = 0;
    always #10 clk = ~clk;
    sff_forward_filter i_sff_forward_filter (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inValid(inValid), .inPort(inPort), .inDa(inDa), .inSa(inSa),
        .inTagged(inTagged), .inVid(inVid), .inBad(inBad), .inIsIp(inIsIp),
        .inIpVersion(inIpVersion), .inIpProto(inIpProto), .inIpv6Mcast(inIpv6Mcast),
        .inHopLimit(inHopLimit), .inNextHdr(inNextHdr), .inHbhNextHdr(inHbhNextHdr),
        .inTailTag(inTailTag), .outValid(outValid), .outDest(outDest), .outDrop(outDrop),
        .outTrap(outTrap), .outMirror(outMirror), .outSrcTag(outSrcTag), .outFid(outFid));
    sff_host_model i_sff_host_model (.clk(clk), .reset(reset), .trapped(outValid && outTrap),
        .srcTag(outSrcTag), .tailTag(inTailTag));
    // =========================================================
    // access tasks
    task stop_test;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_total++;
            stop_test();
        end
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task fr(input logic [2:0] p, input logic [47:0] da, sa, input logic t, input logic [11:0] v);
        @(posedge clk);
        inPort <= p;
        inDa <= da;
        inSa <= sa;
        inTagged <= t;
        inVid <= v;
        inValid <= 1'b1;
        @(posedge clk);
        inValid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task fc(input logic [8:0] e);
        chk({23'h0, outValid, outDrop, outTrap, outMirror, outDest}, {23'h0, e});
    endtask
    // =========================================================
    // scenarios
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(0, sff_pkg::IDX_PORT_DEFAULT_VLAN, 32'h0);
        chk(rdat, 32'h1);
        apb(0, 10'h3FF, 32'h0);
        chk(perr, 32'h1);
        fr(2, 48'hA, 48'hB, 0, 0);
        fc(9'h11B);
        fr(0, 48'hB, 48'hC, 0, 0);
        fc(9'h104);
        fr(2, 48'hC, 48'hB, 0, 0);
        fc(9'h101);
        apb(0, sff_pkg::IDX_LEARNED, 32'h0);
        chk(rdat, 32'h2);
        inIsIp <= 1'b1;
        inIpVersion <= sff_pkg::IPV4_VERSION;
        inIpProto <= sff_pkg::PROTO_IGMP;
        fr(0, 48'hE, 48'hC, 0, 0);
        fc(9'h11E);
        apb(1, sff_pkg::IDX_GCTRL5, 32'h40);
        apb(1, sff_pkg::IDX_GCTRL12, 32'h2);
        fr(1, 48'hE, 48'hD, 0, 0);
        fc(9'h150);
        chk(outSrcTag, 32'h1);
        fr(4, 48'hE, 48'hF, 0, 0);
        fc(9'h102);
        inIpVersion <= 4'h6;
        inIpv6Mcast <= 1'b1;
        foreach (mldTab[k])
        begin
            apb(1, sff_pkg::IDX_GCTRL164, {28'h0, mldTab[k][31:28]});
            inHopLimit <= mldTab[k][27:20];
            inNextHdr <= mldTab[k][19:12];
            inHbhNextHdr <= mldTab[k][11:4];
            fr(0, 48'h3333_0000_0001, 48'hC, 0, 0);
            chk(outTrap, {31'h0, mldTab[k][0]});
        end
        inIsIp <= 1'b0;
        inIpv6Mcast <= 1'b0;
        apb(1, sff_pkg::IDX_PCTRL1, 32'h40);
        apb(1, sff_pkg::IDX_PCTRL1 + 10'h3, 32'h80);
        fr(0, 48'hB, 48'hC, 0, 0);
        fc(9'h12C);
        apb(1, sff_pkg::IDX_PCTRL1, 32'h0);
        apb(1, sff_pkg::IDX_PCTRL1 + 10'h2, 32'h20);
        fr(1, 48'hB, 48'hD, 0, 0);
        fc(9'h12C);
        apb(1, sff_pkg::IDX_GCTRL5, 32'h1);
        fr(1, 48'hB, 48'hD, 0, 0);
        fc(9'h104);
        apb(1, sff_pkg::IDX_PCTRL1 + 10'h1, 32'h40);
        fr(1, 48'hB, 48'hD, 0, 0);
        fc(9'h12C);
        apb(1, sff_pkg::IDX_PCTRL1 + 10'h1, 32'h0);
        apb(1, sff_pkg::IDX_PCTRL1 + 10'h2, 32'h0);
        apb(1, sff_pkg::IDX_GCTRL5, 32'h80);
        fr(0, 48'hE, 48'hC, 1, 12'h005);
        fc(9'h180);
        apb(1, sff_pkg::IDX_VLAN, 32'h80067005);
        apb(1, sff_pkg::IDX_PORT_DEFAULT_VLAN, 32'h5);
        fr(0, 48'hE, 48'h9, 0, 12'h000);
        fc(9'h106);
        chk(outFid, 32'h3);
        apb(1, sff_pkg::IDX_STA_IDX, 32'h0);
        apb(1, sff_pkg::IDX_STA_LO, 32'hE);
        apb(1, sff_pkg::IDX_STA_HI, 32'h20080000);
        fr(0, 48'hE, 48'h9, 1, 12'h000);
        fc(9'h108);
        apb(1, sff_pkg::IDX_PCTRL2 + 10'h3, 32'h40);
        fr(3, 48'h77, 48'h9, 1, 12'h005);
        fc(9'h180);
        stop_test();
    end
endmodule
`default_nettype wire
